// ### rtc_port_regs.vh
// widths, mode codes, reset values and timing counts of the host port
`ifndef RTC_PORT_REGS_VH
`define RTC_PORT_REGS_VH

`define ADDR_W          4
`define DATA_W          4
`define ADDR_RESET      4'h0
`define DATA_RESET      4'h0
`define MODE_SEPARATE   1'b0
`define MODE_ENABLE     1'b1
`define CLK_PERIOD_NS   40
`define PULSE_TIME_NS   120
`define PULSE_CYCLES    ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### periodic_event.v
// periodic event output: pulse or held request on each counter carry
`timescale 1ns/10ps
`include "rtc_port_regs.vh"

module periodic_event #(
	parameter PULSE_LEN = `PULSE_CYCLES
) (
	input  wire clock_i,
	input  wire rst_n_i,
	input  wire carry_i,
	input  wire irq_mode_i,
	input  wire irq_clear_i,
	output reg  event_o
);
	reg [7:0] count_q;

	// set wins over clear in the same cycle
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_o <= 1'b0;
			count_q <= 8'h00;
		end else if (carry_i) begin
			event_o <= 1'b1;
			count_q <= PULSE_LEN[7:0];
		end else if (irq_mode_i) begin
			if (irq_clear_i)
				event_o <= 1'b0;
		end else if (count_q > 8'h01) begin
			count_q <= count_q - 8'h01;
		end else begin
			event_o <= 1'b0;
			count_q <= 8'h00;
		end
	end
endmodule

// ### rtc_host_bus_port.v
// four-bit parallel host port with address latch and chip select gating
`timescale 1ns/10ps
`include "rtc_port_regs.vh"

module rtc_host_bus_port #(
	parameter PULSE_LEN = `PULSE_CYCLES
) (
	input  wire                 clock_i,
	input  wire                 rst_n_i,
	input  wire                 bus_style_i,
	input  wire                 chip_select_low_active_n_i,
	input  wire                 chip_select_power_sense_i,
	input  wire                 addr_latch_i,
	input  wire                 wr_n_rw_i,
	input  wire                 rd_n_en_i,
	input  wire [`ADDR_W-1:0]   host_address_lines_i,
	input  wire [`DATA_W-1:0]   host_data_lines_i,
	output reg  [`DATA_W-1:0]   host_data_lines_o,
	output reg                  host_data_lines_oe_n_o,
	input  wire [`DATA_W-1:0]   reg_rdata_i,
	output reg  [`ADDR_W-1:0]   reg_addr_o,
	output reg  [`DATA_W-1:0]   reg_wdata_o,
	output reg                  reg_write_o,
	output reg                  reg_read_o,
	input  wire                 carry_i,
	input  wire                 irq_mode_i,
	input  wire                 irq_clear_i,
	output reg                  periodic_out_n_o,
	output reg                  periodic_oe_n_o
);
	// ------------------------------------------------------------
	// latch, strobe and event signals
	// ------------------------------------------------------------
	reg  [`ADDR_W-1:0] addr_q;
	reg  [`ADDR_W-1:0] addr_d;
	reg                cs0_n_q;
	reg                cs0_n_d;
	reg                rd_act_q;
	reg                wr_act_q;
	reg  [`DATA_W-1:0] wdata_q;
	reg  [`DATA_W-1:0] wdata_d;
	reg                selected;
	reg                ale_eff;
	reg                rd_act;
	reg                wr_act;
	reg                rd_start;
	reg                wr_done;
	wire [`DATA_W-1:0] rdata_d;
	wire               event_lvl;

	// ------------------------------------------------------------
	// chip select gating
	// ------------------------------------------------------------
	// power sense select acts directly, never latched
	always @* begin
		selected = ~cs0_n_q & chip_select_power_sense_i;
	end

	// cs0 is itself latched: gating the latch on it would lock
	// out reselection, so only the power sense select gates it
	always @* begin
		ale_eff = addr_latch_i & chip_select_power_sense_i;
	end

	// ------------------------------------------------------------
	// address and select latch
	// ------------------------------------------------------------
	always @* begin
		addr_d  = addr_q;
		cs0_n_d = cs0_n_q;
		if (ale_eff) begin
			// transparent while strobe high
			addr_d  = host_address_lines_i;
			cs0_n_d = chip_select_low_active_n_i;
		end
		// strobe low keeps last capture
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q  <= `ADDR_RESET;
			cs0_n_q <= 1'b1;
		end else begin
			addr_q  <= addr_d;
			cs0_n_q <= cs0_n_d;
		end
	end

	// ------------------------------------------------------------
	// strobe decode
	// ------------------------------------------------------------
	always @* begin
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (selected) begin
			if (bus_style_i == `MODE_ENABLE) begin
				// write pin is r/w, read pin is enable
				rd_act = wr_n_rw_i & rd_n_en_i;
				wr_act = ~wr_n_rw_i & rd_n_en_i;
			end else begin
				rd_act = ~rd_n_en_i & wr_n_rw_i;
				wr_act = ~wr_n_rw_i & rd_n_en_i;
			end
		end
		// deselected strobes stay inactive
	end

	// one-cycle marks at read start and write end
	always @* begin
		rd_start = rd_act & ~rd_act_q;
		// commit on trailing edge: data has settled by then
		wr_done  = wr_act_q & ~wr_act;
	end

	// ------------------------------------------------------------
	// write data capture
	// ------------------------------------------------------------
	// last data seen while the write strobe stands is kept
	always @* begin
		wdata_d = wdata_q;
		if (wr_act) begin
			wdata_d = host_data_lines_i;
		end
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
			wdata_q  <= `DATA_RESET;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
			wdata_q  <= wdata_d;
		end
	end

	// ------------------------------------------------------------
	// read data path
	// ------------------------------------------------------------
	// one cycle of lag: data and enable both come from flip-flops
	genvar b;
	generate
		for (b = 0; b < `DATA_W; b = b + 1) begin : g_rdata
			// positive logic: a high line is a one
			assign rdata_d[b] = reg_rdata_i[b];
		end
	endgenerate

	// data lines driven only during a gated read
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_data_lines_o      <= `DATA_RESET;
			host_data_lines_oe_n_o <= 1'b1;
			reg_read_o             <= 1'b0;
		end else begin
			host_data_lines_o      <= rdata_d;
			host_data_lines_oe_n_o <= ~rd_act;
			reg_read_o             <= rd_start;
		end
	end

	// ------------------------------------------------------------
	// register side
	// ------------------------------------------------------------
	// latched address picks the register
	// write pulse and data leave together, one cycle after the end
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_addr_o  <= `ADDR_RESET;
			reg_wdata_o <= `DATA_RESET;
			reg_write_o <= 1'b0;
		end else begin
			reg_addr_o  <= addr_q;
			reg_wdata_o <= wdata_q;
			reg_write_o <= wr_done;
		end
	end

	// ------------------------------------------------------------
	// periodic event, independent of both selects
	// ------------------------------------------------------------
	// carry wins over a same-cycle clear inside the event block
	periodic_event #(
		.PULSE_LEN (PULSE_LEN)
	) u_event (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.carry_i     (carry_i),
		.irq_mode_i  (irq_mode_i),
		.irq_clear_i (irq_clear_i),
		.event_o     (event_lvl)
	);

	// open drain: pin only pulls low, the enable carries the event
	// limitation: no pull-up inside, the board must provide it
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			periodic_out_n_o <= 1'b1;
			periodic_oe_n_o  <= 1'b1;
		end else begin
			periodic_out_n_o <= 1'b0;
			periodic_oe_n_o  <= ~event_lvl;
		end
	end
endmodule

// ### reg_file_model.sv
// register file standing behind the host port
`timescale 1ns/10ps
module reg_file_model (
	input  wire logic       clock_i,
	input  wire logic       wr_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [3:0] data_i,
	output wire logic [3:0] data_o
);
	logic [3:0] mem_q [16];
	always @(posedge clock_i) if (wr_i) mem_q[addr_i] <= data_i;
	assign data_o = mem_q[addr_i];
endmodule

// ### host_port_checker.sv
// concurrent checks on the host port pins
`timescale 1ns/10ps
module host_port_checker (
	input wire logic clock_i, rst_n_i, bus_style_i, addr_latch_i,
	input wire logic chip_select_low_active_n_i, chip_select_power_sense_i,
	input wire logic wr_n_rw_i, rd_n_en_i, carry_i, irq_mode_i, irq_clear_i,
	input wire logic host_data_lines_oe_n_o, reg_write_o, periodic_oe_n_o,
	input wire logic [3:0] host_data_lines_o, reg_rdata_i
);
	logic cs_q;
	// mirrors the registered select latch, gated by power sense select
	wire sel = !cs_q && chip_select_power_sense_i;
	wire rd = sel && wr_n_rw_i && (bus_style_i ? rd_n_en_i : !rd_n_en_i);
	wire wr = sel && !wr_n_rw_i && rd_n_en_i;
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) cs_q <= 1'b1;
		else if (addr_latch_i && chip_select_power_sense_i)
			cs_q <= chip_select_low_active_n_i;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd_on; rd [*2] |-> !host_data_lines_oe_n_o; endproperty
	a_rd_on: assert property (p_rd_on) else $error("read not driven");
	property p_rd_off; !rd [*2] |-> host_data_lines_oe_n_o; endproperty
	a_rd_off: assert property (p_rd_off) else $error("bus driven");
	property p_cs1; !chip_select_power_sense_i [*2] |-> host_data_lines_oe_n_o;
	endproperty
	a_cs1: assert property (p_cs1) else $error("driven unselected");
	property p_data;
		!host_data_lines_oe_n_o |-> host_data_lines_o == $past(reg_rdata_i);
	endproperty
	a_data: assert property (p_data) else $error("read data wrong");
	property p_wr; reg_write_o |-> $past(wr, 2) && !$past(wr); endproperty
	a_wr: assert property (p_wr) else $error("write not at end");
	property p_wr1; reg_write_o |=> !reg_write_o; endproperty
	a_wr1: assert property (p_wr1) else $error("write pulse long");
	property p_evt; carry_i |-> ##2 !periodic_oe_n_o; endproperty
	a_evt: assert property (p_evt) else $error("no event");
	property p_len; !irq_mode_i && $fell(periodic_oe_n_o) |->
		!periodic_oe_n_o [*3] ##1 periodic_oe_n_o; endproperty
	a_len: assert property (p_len) else $error("pulse length");
	property p_hold; irq_mode_i && !irq_clear_i && !$past(irq_clear_i) &&
		!periodic_oe_n_o |=> !periodic_oe_n_o; endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
endmodule
bind rtc_host_bus_port host_port_checker u_host_port_checker (.*);

// ### tb_rtc_host_bus_port.sv
// self-checking bench for the host port
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module tb_rtc_host_bus_port;
	logic clock_i = 1'b0, rst_n_i = 1'b0, bus_style_i = 1'b0;
	logic addr_latch_i = 1'b1, chip_select_low_active_n_i = 1'b0;
	logic chip_select_power_sense_i = 1'b1, wr_n_rw_i = 1'b1, rd_n_en_i = 1'b1;
	logic carry_i = 1'b0, irq_mode_i = 1'b0, irq_clear_i = 1'b0;
	logic [3:0] host_address_lines_i = 4'h0, host_data_lines_i = 4'h0;
	wire [3:0] host_data_lines_o, reg_rdata_i, reg_addr_o, reg_wdata_o;
	wire host_data_lines_oe_n_o, reg_write_o, reg_read_o;
	wire periodic_out_n_o, periodic_oe_n_o;
	logic [11:0] rows [4] = '{12'h015, 12'h12a, 12'h0f6, 12'h103};
	int errors = 0, compares = 0;
	rtc_host_bus_port u_rtc_host_bus_port (.*);
	reg_file_model u_reg_file_model (.clock_i, .wr_i(reg_write_o),
		.addr_i(reg_addr_o), .data_i(reg_wdata_o), .data_o(reg_rdata_i));
	initial forever #20 clock_i = ~clock_i;
	task complete_run;
		if (errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// write strobe doubles as r/w select in enable style
	task acc(input logic s, w, input logic [3:0] a, d);
		@(posedge clock_i);
		bus_style_i <= s;
		host_address_lines_i <= a;
		host_data_lines_i <= d;
		wr_n_rw_i <= !w;
		rd_n_en_i <= w | s;
		@(posedge clock_i);
		#1 if (!w) `CHK(reg_read_o, 1'b1)
		repeat (2) @(posedge clock_i);
		#1 if (!w) `CHK({host_data_lines_oe_n_o, host_data_lines_o}, {1'b0, d})
		if (!w) `CHK(reg_read_o, 1'b0)
		@(posedge clock_i);
		wr_n_rw_i <= 1'b1;
		rd_n_en_i <= !s;
		repeat (3) @(posedge clock_i);
	endtask
	task evt(input logic m);
		@(posedge clock_i);
		irq_mode_i <= m;
		carry_i <= 1'b1;
		@(posedge clock_i) carry_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1 `CHK(periodic_oe_n_o, 1'b0)
		`CHK(periodic_out_n_o, 1'b0)
		repeat (3) @(posedge clock_i);
		#1 `CHK(periodic_oe_n_o, !m)
		@(posedge clock_i) irq_clear_i <= 1'b1;
		@(posedge clock_i) irq_clear_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1 `CHK(periodic_oe_n_o, 1'b1)
	endtask
	initial begin
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		#1 `CHK(host_data_lines_oe_n_o, 1'b1)
		for (int i = 0; i < 4; i++) begin
			acc(rows[i][8], 1'b1, rows[i][7:4], rows[i][3:0]);
			acc(rows[i][8], 1'b0, rows[i][7:4], rows[i][3:0]);
		end
		// address and select now frozen, new address must be ignored
		@(posedge clock_i) addr_latch_i <= 1'b0;
		chip_select_low_active_n_i <= 1'b1;
		acc(1'b0, 1'b0, 4'h9, rows[3][3:0]);
		@(posedge clock_i) chip_select_power_sense_i <= 1'b0;
		rd_n_en_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1 `CHK(host_data_lines_oe_n_o, 1'b1)
		@(posedge clock_i) rd_n_en_i <= 1'b1;
		evt(1'b0);
		evt(1'b1);
		complete_run;
	end
	initial begin
		#20000;
		errors++;
		complete_run;
	end
endmodule
